// file: inc/rmi_pkg.sv
package rmi_pkg;

  // register file map
  localparam logic [7:0] PORT0_ADDR = 8'h00;
  localparam logic [7:0] PORT2_ADDR = 8'h02;
  localparam logic [7:0] PORT3_ADDR = 8'h03;
  localparam logic [7:0] GP_FIRST = 8'h04;
  localparam logic [7:0] GP_LAST = 8'h7f;
  localparam logic [7:0] CTRL_FIRST = 8'hf0;
  localparam logic [7:0] SERIAL_ADDR = 8'hf0;
  localparam logic [7:0] CNT_MODE_ADDR = 8'hf1;
  localparam logic [7:0] CNT1_VAL_ADDR = 8'hf2;
  localparam logic [7:0] CNT1_DIV_ADDR = 8'hf3;
  localparam logic [7:0] CNT0_VAL_ADDR = 8'hf4;
  localparam logic [7:0] CNT0_DIV_ADDR = 8'hf5;
  localparam logic [7:0] P2_DIR_ADDR = 8'hf6;
  localparam logic [7:0] P3_CFG_ADDR = 8'hf7;
  localparam logic [7:0] P01_CFG_ADDR = 8'hf8;
  localparam logic [7:0] IRQ_RANK_ADDR = 8'hf9;
  localparam logic [7:0] IRQ_PEND_ADDR = 8'hfa;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hfb;
  localparam logic [7:0] COND_ADDR = 8'hfc;
  localparam logic [7:0] WGB_ADDR = 8'hfd;
  localparam logic [7:0] STACK_HI_ADDR = 8'hfe;
  localparam logic [7:0] STACK_LO_ADDR = 8'hff;

  // answer for unimplemented or write-only locations
  localparam logic [7:0] IDLE_READ = 8'hff;

  // port_zero_one_config fields
  localparam int P0_LO_MODE_LSB = 0;
  localparam int P01_STACK_INT_BIT = 2;
  localparam int P0_HI_MODE_LSB = 6;
  localparam logic [1:0] P0_MODE_OUT = 2'h0;
  localparam logic [1:0] P0_MODE_IN = 2'h1;
  localparam logic [1:0] P0_MODE_ADDR = 2'h2;
  // port_three_config: data-space select on port 3 bit 1
  localparam int P3_DSEL_EN_BIT = 3;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h000c;
  localparam logic [7:0] P01_CFG_RESET = 8'h4d;
  localparam logic [7:0] P2_DIR_RESET = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;

  // bus timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int AS_LOW_NS = 80;
  localparam int DS_RD_NS = 250;
  localparam int DS_WR_NS = 160;
  localparam int DS_TO_AS_NS = 70;
  localparam int SYNC_CYC = 2;
  localparam logic [3:0] AS_LOW_CYC =
    4'((AS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] DS_RD_CYC =
    4'((DS_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);
  localparam logic [3:0] DS_WR_CYC =
    4'((DS_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOV_CYC =
    4'((DS_TO_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_HOLD = 3'b011,
    BUS_DATA = 3'b010,
    BUS_RECOV = 3'b110
  } rmi_bus_e;

endpackage

// file: verilog/rmi_memory_interface.sv
`timescale 1ns/1ps
module rmi_memory_interface
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fetch_req,
  output logic fetch_ack,
  output logic [7:0] fetch_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_new,
  output logic [15:0] pc,
  input wire logic data_req,
  input wire logic data_wr,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] data_wdata,
  output logic data_ack,
  output logic [7:0] data_rdata,
  output logic busy,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic rf_short,
  input wire logic [7:0] rf_addr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata,
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [15:0] stack_addr,
  output logic stack_external,
  input wire logic [7:0] muxed_addr_data_port_in,
  output logic [7:0] muxed_addr_data_port_out,
  output logic muxed_addr_data_port_oe_n,
  output logic addr_latch_strobe_n,
  output logic xfer_strobe_n,
  output logic read_write,
  output logic data_space_select_n,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe_n,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe_n,
  input wire logic [3:0] port3_in,
  output logic [3:0] port3_out,
  input wire logic serial_rx_event,
  input wire logic serial_tx_event,
  input wire logic counter0_event,
  input wire logic counter1_event,
  output logic [5:0] irq_req
);

  rmi_pkg::rmi_bus_e bus_state;
  logic [3:0] bus_cnt;
  logic bus_is_fetch;
  logic bus_is_write;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] rd_capture;

  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;
  logic [7:0] p2_meta;
  logic [7:0] p2_sync;
  logic [3:0] p3_meta;
  logic [3:0] p3_sync;
  logic [3:0] p3_prev;

  logic [7:0] gp_mem [4:127];
  logic [7:0] port_zero_data;
  logic [7:0] port_two_data;
  logic [7:0] port_three_data;
  logic [7:0] serial_data_reg;
  logic [7:0] counter_mode_ctrl;
  logic [7:0] counter1_value;
  logic [7:0] counter1_divider;
  logic [7:0] counter0_value;
  logic [7:0] counter0_divider;
  logic [7:0] port_two_direction;
  logic [7:0] port_three_config;
  logic [7:0] port_zero_one_config;
  logic [7:0] interrupt_rank_ctrl;
  logic [5:0] interrupt_pending;
  logic [7:0] interrupt_enable_mask;
  logic [7:0] condition_code_reg;
  logic [7:0] working_group_base;
  logic [7:0] stack_top_high;
  logic [7:0] stack_top_low;

  logic [7:0] eff_addr;
  logic [5:0] irq_src;
  logic [5:0] next_pending;
  logic take_data;
  logic take_fetch;
  logic [1:0] p0_lo_mode;
  logic [1:0] p0_hi_mode;
  logic dsel_enabled;
  logic [15:0] next_bus_addr;

  function automatic logic [7:0] resolve_addr(
    input logic short_mode,
    input logic [7:0] full,
    input logic [7:0] group_base
  );
    // group base high nibble selects one of the 16-byte groups
    if (short_mode)
    begin
      return {group_base[7:4], full[3:0]};
    end
    return full;
  endfunction

  function automatic logic is_gp(input logic [7:0] a);
    return (a >= rmi_pkg::GP_FIRST) && (a <= rmi_pkg::GP_LAST);
  endfunction

  function automatic logic [7:0] pin_merge(
    input logic [7:0] pins,
    input logic [7:0] latch,
    input logic [7:0] is_input
  );
    return (pins & is_input) | (latch & ~is_input);
  endfunction

  assign eff_addr = resolve_addr(rf_short, rf_addr, working_group_base);
  assign p0_lo_mode = port_zero_one_config[rmi_pkg::P0_LO_MODE_LSB +: 2];
  assign p0_hi_mode = port_zero_one_config[rmi_pkg::P0_HI_MODE_LSB +: 2];
  assign dsel_enabled = port_three_config[rmi_pkg::P3_DSEL_EN_BIT];
  assign take_data = data_req && (bus_state == rmi_pkg::BUS_IDLE);
  assign take_fetch = fetch_req && !data_req
    && (bus_state == rmi_pkg::BUS_IDLE);
  // upper address settles with the strobe falling, one cycle before it rises
  assign next_bus_addr = take_data ? data_addr
    : (take_fetch ? pc : bus_addr);

  // pin synchronisers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      p1_meta <= 8'h00;
      p1_sync <= 8'h00;
      p0_meta <= 8'h00;
      p0_sync <= 8'h00;
      p2_meta <= 8'h00;
      p2_sync <= 8'h00;
      p3_meta <= 4'h0;
      p3_sync <= 4'h0;
      p3_prev <= 4'h0;
    end
    else
    begin
      p1_meta <= muxed_addr_data_port_in;
      p1_sync <= p1_meta;
      p0_meta <= port0_in;
      p0_sync <= p0_meta;
      p2_meta <= port2_in;
      p2_sync <= p2_meta;
      p3_meta <= port3_in;
      p3_sync <= p3_meta;
      p3_prev <= p3_sync;
    end
  end

  // program counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pc <= rmi_pkg::PC_RESET;
    end
    else if (pc_load)
    begin
      pc <= pc_new;
    end
    else if (take_fetch)
    begin
      pc <= pc + 16'h0001;
    end
  end

  // external bus sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bus_state <= rmi_pkg::BUS_IDLE;
      bus_cnt <= 4'h0;
      bus_is_fetch <= 1'b0;
      bus_is_write <= 1'b0;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      rd_capture <= 8'h00;
      busy <= 1'b0;
      addr_latch_strobe_n <= 1'b1;
      xfer_strobe_n <= 1'b1;
      read_write <= 1'b1;
      data_space_select_n <= 1'b1;
      muxed_addr_data_port_out <= 8'h00;
      muxed_addr_data_port_oe_n <= 1'b1;
      fetch_ack <= 1'b0;
      fetch_data <= 8'h00;
      data_ack <= 1'b0;
      data_rdata <= 8'h00;
    end
    else
    begin
      fetch_ack <= 1'b0;
      data_ack <= 1'b0;
      unique case (bus_state)
        rmi_pkg::BUS_IDLE:
        begin
          if (take_data || take_fetch)
          begin
            bus_state <= rmi_pkg::BUS_ADDR;
            bus_cnt <= rmi_pkg::AS_LOW_CYC;
            bus_is_fetch <= take_fetch;
            bus_is_write <= take_data && data_wr;
            bus_addr <= take_data ? data_addr : pc;
            bus_wdata <= data_wdata;
            busy <= 1'b1;
            addr_latch_strobe_n <= 1'b0;
            read_write <= !(take_data && data_wr);
            data_space_select_n <= !(take_data && dsel_enabled);
            muxed_addr_data_port_out <= take_data ? data_addr[7:0]
              : pc[7:0];
            muxed_addr_data_port_oe_n <= 1'b0;
          end
        end
        rmi_pkg::BUS_ADDR:
        begin
          if (bus_cnt == 4'h1)
          begin
            // address stays on the lines after strobe rises
            bus_state <= rmi_pkg::BUS_HOLD;
            addr_latch_strobe_n <= 1'b1;
          end
          else
          begin
            bus_cnt <= bus_cnt - 4'h1;
          end
        end
        rmi_pkg::BUS_HOLD:
        begin
          // latch phase over before data strobe falls
          bus_state <= rmi_pkg::BUS_DATA;
          bus_cnt <= bus_is_write ? rmi_pkg::DS_WR_CYC
            : rmi_pkg::DS_RD_CYC;
          xfer_strobe_n <= 1'b0;
          muxed_addr_data_port_out <= bus_wdata;
          muxed_addr_data_port_oe_n <= !bus_is_write;
        end
        rmi_pkg::BUS_DATA:
        begin
          if (bus_cnt == 4'h1)
          begin
            bus_state <= rmi_pkg::BUS_RECOV;
            bus_cnt <= rmi_pkg::RECOV_CYC;
            xfer_strobe_n <= 1'b1;
            rd_capture <= p1_sync;
          end
          else
          begin
            bus_cnt <= bus_cnt - 4'h1;
          end
        end
        rmi_pkg::BUS_RECOV:
        begin
          muxed_addr_data_port_oe_n <= 1'b1;
          if (bus_cnt == 4'h1)
          begin
            bus_state <= rmi_pkg::BUS_IDLE;
            busy <= 1'b0;
            read_write <= 1'b1;
            data_space_select_n <= 1'b1;
            fetch_ack <= bus_is_fetch;
            data_ack <= !bus_is_fetch;
            if (bus_is_fetch)
            begin
              fetch_data <= rd_capture;
            end
            else if (!bus_is_write)
            begin
              data_rdata <= rd_capture;
            end
          end
          else
          begin
            bus_cnt <= bus_cnt - 4'h1;
          end
        end
        default:
        begin
          bus_state <= rmi_pkg::BUS_IDLE;
          busy <= 1'b0;
          addr_latch_strobe_n <= 1'b1;
          xfer_strobe_n <= 1'b1;
          muxed_addr_data_port_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // general registers; writes outside the map are dropped
  always_ff @(posedge mclk)
  begin
    if (rf_wr && is_gp(eff_addr))
    begin
      gp_mem[eff_addr[6:0]] <= rf_wdata;
    end
  end

  // port and control registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      port_zero_data <= rmi_pkg::REG_RESET;
      port_two_data <= rmi_pkg::REG_RESET;
      port_three_data <= rmi_pkg::REG_RESET;
      serial_data_reg <= rmi_pkg::REG_RESET;
      counter_mode_ctrl <= rmi_pkg::REG_RESET;
      counter1_value <= rmi_pkg::REG_RESET;
      counter1_divider <= rmi_pkg::REG_RESET;
      counter0_value <= rmi_pkg::REG_RESET;
      counter0_divider <= rmi_pkg::REG_RESET;
      port_two_direction <= rmi_pkg::P2_DIR_RESET;
      port_three_config <= rmi_pkg::REG_RESET;
      port_zero_one_config <= rmi_pkg::P01_CFG_RESET;
      interrupt_rank_ctrl <= rmi_pkg::REG_RESET;
      interrupt_enable_mask <= rmi_pkg::REG_RESET;
      condition_code_reg <= rmi_pkg::REG_RESET;
      working_group_base <= rmi_pkg::REG_RESET;
    end
    else if (rf_wr)
    begin
      unique case (eff_addr)
        rmi_pkg::PORT0_ADDR: port_zero_data <= rf_wdata;
        rmi_pkg::PORT2_ADDR: port_two_data <= rf_wdata;
        rmi_pkg::PORT3_ADDR: port_three_data <= rf_wdata;
        rmi_pkg::SERIAL_ADDR: serial_data_reg <= rf_wdata;
        rmi_pkg::CNT_MODE_ADDR: counter_mode_ctrl <= rf_wdata;
        rmi_pkg::CNT1_VAL_ADDR: counter1_value <= rf_wdata;
        rmi_pkg::CNT1_DIV_ADDR: counter1_divider <= rf_wdata;
        rmi_pkg::CNT0_VAL_ADDR: counter0_value <= rf_wdata;
        rmi_pkg::CNT0_DIV_ADDR: counter0_divider <= rf_wdata;
        rmi_pkg::P2_DIR_ADDR: port_two_direction <= rf_wdata;
        rmi_pkg::P3_CFG_ADDR: port_three_config <= rf_wdata;
        rmi_pkg::P01_CFG_ADDR: port_zero_one_config <= rf_wdata;
        rmi_pkg::IRQ_RANK_ADDR: interrupt_rank_ctrl <= rf_wdata;
        rmi_pkg::IRQ_MASK_ADDR: interrupt_enable_mask <= rf_wdata;
        rmi_pkg::COND_ADDR: condition_code_reg <= rf_wdata;
        rmi_pkg::WGB_ADDR: working_group_base <= rf_wdata;
        default:
        begin
        end
      endcase
    end
  end

  // stack pointer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stack_top_high <= rmi_pkg::REG_RESET;
      stack_top_low <= rmi_pkg::REG_RESET;
    end
    else if (rf_wr && eff_addr == rmi_pkg::STACK_HI_ADDR)
    begin
      stack_top_high <= rf_wdata;
    end
    else if (rf_wr && eff_addr == rmi_pkg::STACK_LO_ADDR)
    begin
      stack_top_low <= rf_wdata;
    end
    else if (stack_push != stack_pop)
    begin
      if (port_zero_one_config[rmi_pkg::P01_STACK_INT_BIT])
      begin
        stack_top_low <= stack_push ? stack_top_low - 8'h01
          : stack_top_low + 8'h01;
      end
      else
      begin
        {stack_top_high, stack_top_low} <= stack_push
          ? {stack_top_high, stack_top_low} - 16'h0001
          : {stack_top_high, stack_top_low} + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stack_addr <= 16'h0000;
      stack_external <= 1'b0;
    end
    else
    begin
      stack_external <= !port_zero_one_config[rmi_pkg::P01_STACK_INT_BIT];
      if (port_zero_one_config[rmi_pkg::P01_STACK_INT_BIT])
      begin
        stack_addr <= {8'h00, stack_top_low};
      end
      else
      begin
        stack_addr <= {stack_top_high, stack_top_low};
      end
    end
  end

  // interrupt sources: falling edges of port 3 inputs, plus events
  always_comb
  begin
    irq_src[0] = p3_prev[2] && !p3_sync[2];
    irq_src[1] = p3_prev[3] && !p3_sync[3];
    irq_src[2] = p3_prev[1] && !p3_sync[1] && !dsel_enabled;
    irq_src[3] = (p3_prev[0] && !p3_sync[0]) || serial_rx_event;
    irq_src[4] = counter0_event || serial_tx_event;
    irq_src[5] = counter1_event;
    next_pending = interrupt_pending;
    if (rf_wr && eff_addr == rmi_pkg::IRQ_PEND_ADDR)
    begin
      next_pending = rf_wdata[5:0];
    end
    // a new event beats a clearing write
    next_pending = next_pending | irq_src;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_pending <= 6'h00;
      irq_req <= 6'h00;
    end
    else
    begin
      interrupt_pending <= next_pending;
      irq_req <= next_pending & interrupt_enable_mask[5:0];
    end
  end

  // register read port
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rf_rdata <= rmi_pkg::IDLE_READ;
    end
    else if (rf_rd)
    begin
      if (is_gp(eff_addr))
      begin
        rf_rdata <= gp_mem[eff_addr[6:0]];
      end
      else
      begin
        unique case (eff_addr)
          rmi_pkg::PORT0_ADDR: rf_rdata <= pin_merge(p0_sync,
            port_zero_data, ~port0_oe_n);
          rmi_pkg::PORT2_ADDR: rf_rdata <= pin_merge(p2_sync,
            port_two_data, port_two_direction);
          rmi_pkg::PORT3_ADDR: rf_rdata <= {port_three_data[7:4], p3_sync};
          rmi_pkg::SERIAL_ADDR: rf_rdata <= serial_data_reg;
          rmi_pkg::CNT_MODE_ADDR: rf_rdata <= counter_mode_ctrl;
          rmi_pkg::CNT1_VAL_ADDR: rf_rdata <= counter1_value;
          rmi_pkg::CNT0_VAL_ADDR: rf_rdata <= counter0_value;
          rmi_pkg::IRQ_PEND_ADDR: rf_rdata <= {2'b00, interrupt_pending};
          rmi_pkg::IRQ_MASK_ADDR: rf_rdata <= interrupt_enable_mask;
          rmi_pkg::COND_ADDR: rf_rdata <= condition_code_reg;
          rmi_pkg::WGB_ADDR: rf_rdata <= working_group_base;
          rmi_pkg::STACK_HI_ADDR: rf_rdata <= stack_top_high;
          rmi_pkg::STACK_LO_ADDR: rf_rdata <= stack_top_low;
          default: rf_rdata <= rmi_pkg::IDLE_READ;
        endcase
      end
    end
  end

  // port drivers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      port0_out <= 8'h00;
      port0_oe_n <= 8'hff;
      port2_out <= 8'h00;
      port2_oe_n <= 8'hff;
      port3_out <= 4'h0;
    end
    else
    begin
      port2_out <= port_two_data;
      port2_oe_n <= port_two_direction;
      port3_out <= port_three_data[7:4];
      if (p0_lo_mode[1])
      begin
        port0_out[3:0] <= next_bus_addr[11:8];
        port0_oe_n[3:0] <= 4'h0;
      end
      else
      begin
        port0_out[3:0] <= port_zero_data[3:0];
        port0_oe_n[3:0] <= {4{p0_lo_mode == rmi_pkg::P0_MODE_IN}};
      end
      if (p0_hi_mode[1] && p0_lo_mode[1])
      begin
        port0_out[7:4] <= next_bus_addr[15:12];
        port0_oe_n[7:4] <= 4'h0;
      end
      else
      begin
        port0_out[7:4] <= port_zero_data[7:4];
        port0_oe_n[7:4] <= {4{p0_hi_mode != rmi_pkg::P0_MODE_OUT}};
      end
    end
  end

  // port 1 has no register-file location; it only serves the bus

endmodule

// file: verif/rmi_mem_assertions.sv
`timescale 1ns/1ps
module rmi_mem_assertions
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_latch_strobe_n,
  input wire logic xfer_strobe_n,
  input wire logic read_write,
  input wire logic data_space_select_n,
  input wire logic muxed_addr_data_port_oe_n,
  input wire logic busy,
  input wire logic fetch_ack,
  input wire logic data_ack,
  input wire logic [15:0] stack_addr,
  input wire logic stack_external
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_rd_low;
    !xfer_strobe_n[*5] ##1 xfer_strobe_n;
  endsequence
  sequence s_wr_low;
    !xfer_strobe_n[*2] ##1 xfer_strobe_n;
  endsequence

  property p_as_pulse;
    $fell(addr_latch_strobe_n) |=> addr_latch_strobe_n;
  endproperty
  a_as_pulse: assert property (p_as_pulse)
    else $error("address strobe low too long");
  property p_as_ds;
    $fell(addr_latch_strobe_n) |-> ##2 $fell(xfer_strobe_n);
  endproperty
  a_as_ds: assert property (p_as_ds)
    else $error("data strobe not two cycles after address");
  property p_rd_ds;
    $fell(xfer_strobe_n) && read_write |-> s_rd_low;
  endproperty
  a_rd_ds: assert property (p_rd_ds)
    else $error("read data strobe width wrong");
  property p_wr_ds;
    $fell(xfer_strobe_n) && !read_write |-> s_wr_low;
  endproperty
  a_wr_ds: assert property (p_wr_ds)
    else $error("write data strobe width wrong");
  property p_ds_busy;
    !xfer_strobe_n |-> busy;
  endproperty
  a_ds_busy: assert property (p_ds_busy)
    else $error("data strobe low outside a transfer");
  property p_rd_float;
    !xfer_strobe_n && read_write |-> muxed_addr_data_port_oe_n;
  endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("bus driven during read data phase");
  property p_wr_drive;
    !xfer_strobe_n && !read_write |-> !muxed_addr_data_port_oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("bus not driven during write data phase");
  property p_addr_drive;
    !addr_latch_strobe_n |-> !muxed_addr_data_port_oe_n;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("bus not driven during address phase");
  property p_ack;
    $rose(xfer_strobe_n) |-> ##1 (fetch_ack || data_ack);
  endproperty
  a_ack: assert property (p_ack)
    else $error("no completion after data strobe");
  property p_dsel;
    !data_space_select_n |-> busy;
  endproperty
  a_dsel: assert property (p_dsel)
    else $error("data space select outside a transfer");
  property p_int_stack;
    !stack_external |-> stack_addr[15:8] == 8'h00;
  endproperty
  a_int_stack: assert property (p_int_stack)
    else $error("internal stack pointer high byte set");
endmodule

bind rmi_memory_interface rmi_mem_assertions u_chk
(
  .mclk(mclk),
  .rst(rst),
  .addr_latch_strobe_n(addr_latch_strobe_n),
  .xfer_strobe_n(xfer_strobe_n),
  .read_write(read_write),
  .data_space_select_n(data_space_select_n),
  .muxed_addr_data_port_oe_n(muxed_addr_data_port_oe_n),
  .busy(busy),
  .fetch_ack(fetch_ack),
  .data_ack(data_ack),
  .stack_addr(stack_addr),
  .stack_external(stack_external)
);

// file: verif/rmi_mem_model.sv
`timescale 1ns/1ps
module rmi_mem_model
(
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic rw,
  input wire logic dsel_n,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p0_out,
  output logic [7:0] p1_in,
  output logic [15:0] addr,
  output logic dm
);
  logic [7:0] mem [0:511];
  logic [7:0] last;
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'(i) ^ (i < 256 ? 8'h5a : 8'ha5);
    addr = 16'h0000;
    dm = 1'b0;
    last = 8'h00;
  end
  // address taken as the strobe rises
  always @(posedge as_n)
  begin
    addr = {p0_out, p1_out};
    dm = !dsel_n;
  end
  always @(posedge ds_n)
  begin
    if (!rw)
      mem[{dm, addr[7:0]}] = p1_out;
    last = p1_in;
  end
  // released bus shows the inverse of the last value
  assign p1_in = (!ds_n && rw) ? mem[{dm, addr[7:0]}] : ~last;
endmodule

// file: verif/tb_romless_mcu_memory_interface.sv
`timescale 1ns/1ps
module tb_romless_mcu_memory_interface;
  logic mclk, rst, fetch_req, pc_load, data_req, data_wr;
  logic rf_rd, rf_wr, rf_short, stack_push, stack_pop;
  logic fetch_ack, data_ack, busy, stack_external, as_n, ds_n, rw;
  logic dsel_n, mdm;
  logic [15:0] pc_new, data_addr, pc, stack_addr, ma;
  logic [7:0] data_wdata, rf_addr, rf_wdata, rf_rdata, fetch_data;
  logic [7:0] data_rdata, p1_in, p1_out, p0_in, p0_out, p2_oe_n, q;
  logic [3:0] p3_in;
  logic [7:0] p0_oe_n, p2_out;
  logic [5:0] irq;
  logic [7:0] bad [3] = '{8'h01, 8'h80, 8'hef};
  int err_count, compares;

  rmi_memory_interface dut
  (
    .mclk(mclk), .rst(rst), .fetch_req(fetch_req),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .pc_load(pc_load), .pc_new(pc_new), .pc(pc),
    .data_req(data_req), .data_wr(data_wr), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_ack(data_ack),
    .data_rdata(data_rdata), .busy(busy),
    .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_short(rf_short),
    .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_addr(stack_addr), .stack_external(stack_external),
    .muxed_addr_data_port_in(p1_in),
    .muxed_addr_data_port_out(p1_out),
    .muxed_addr_data_port_oe_n(),
    .addr_latch_strobe_n(as_n), .xfer_strobe_n(ds_n),
    .read_write(rw), .data_space_select_n(dsel_n),
    .port0_in(p0_in), .port0_out(p0_out), .port0_oe_n(p0_oe_n),
    .port2_in(8'h00), .port2_out(p2_out), .port2_oe_n(p2_oe_n),
    .port3_in(p3_in), .port3_out(),
    .serial_rx_event(1'b0), .serial_tx_event(1'b0),
    .counter0_event(1'b0), .counter1_event(1'b0), .irq_req(irq)
  );

  rmi_mem_model mem
  (
    .as_n(as_n), .ds_n(ds_n), .rw(rw), .dsel_n(dsel_n),
    .p1_out(p1_out), .p0_out(p0_out), .p1_in(p1_in),
    .addr(ma), .dm(mdm)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rfw(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(negedge mclk);
    rf_wr = 1'b1;
    rf_addr = a;
    rf_wdata = d;
    rf_short = s;
    @(negedge mclk);
    rf_wr = 1'b0;
    rf_short = 1'b0;
  endtask

  task rfr(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    rf_rd = 1'b1;
    rf_addr = a;
    @(negedge mclk);
    rf_rd = 1'b0;
    d = rf_rdata;
  endtask

  // request held until the design takes it
  task bus(input logic f, input logic w, input logic [15:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    fetch_req = f;
    data_req = !f;
    data_wr = w;
    data_addr = a;
    data_wdata = d;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    fetch_req = 1'b0;
    data_req = 1'b0;
    while (fetch_ack !== 1'b1 && data_ack !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n < 40), 16'h0001);
  endtask

  task summarize;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    err_count++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    {fetch_req, pc_load, data_req, data_wr} = 4'h0;
    {rf_rd, rf_wr, rf_short, stack_push, stack_pop} = 5'h00;
    pc_new = 16'h0000;
    data_addr = 16'h0000;
    {data_wdata, rf_addr, rf_wdata, p0_in} = 32'h0000_0000;
    p3_in = 4'hf;
    repeat (20) @(negedge mclk);
    chk(pc, rmi_pkg::PC_RESET);
    chk({as_n, ds_n, rw}, 3'b111);
    chk(p2_oe_n, rmi_pkg::P2_DIR_RESET);
    chk(p0_oe_n, 8'hff);
    rst = 1'b0;
    bus(1'b1, 1'b0, 16'h0000, 8'h00);
    chk(fetch_data, 8'h0c ^ 8'h5a);
    chk(ma[7:0], 8'h0c);
    chk(pc, 16'h000d);
    rfw(rmi_pkg::P3_CFG_ADDR, 8'h08, 1'b0);
    rfw(rmi_pkg::P01_CFG_ADDR, 8'h86, 1'b0);
    bus(1'b0, 1'b0, 16'h1234, 8'h00);
    chk(data_rdata, 8'h34 ^ 8'ha5);
    chk(ma, 16'h1234);
    chk(mdm, 1'b1);
    rfw(rmi_pkg::P01_CFG_ADDR, 8'h06, 1'b0);
    bus(1'b0, 1'b0, 16'h0567, 8'h00);
    chk(ma[11:0], 12'h567);
    bus(1'b0, 1'b1, 16'h0040, 8'h3c);
    bus(1'b0, 1'b0, 16'h0040, 8'h00);
    chk(data_rdata, 8'h3c);
    @(negedge mclk);
    pc_load = 1'b1;
    pc_new = 16'h00f0;
    @(negedge mclk);
    pc_load = 1'b0;
    bus(1'b1, 1'b0, 16'h0000, 8'h00);
    chk(fetch_data, 8'hf0 ^ 8'h5a);
    chk(mdm, 1'b0);
    rfw(8'h7f, 8'h77, 1'b0);
    rfr(8'h7f, q);
    chk(q, 8'h77);
    rfw(rmi_pkg::WGB_ADDR, 8'h20, 1'b0);
    rfw(8'h03, 8'h99, 1'b1);
    rfr(8'h23, q);
    chk(q, 8'h99);
    for (int i = 0; i < 3; i++)
    begin
      rfw(bad[i], 8'h5a, 1'b0);
      rfr(bad[i], q);
      chk(q, rmi_pkg::IDLE_READ);
    end
    rfw(rmi_pkg::P2_DIR_ADDR, 8'h0f, 1'b0);
    @(negedge mclk);
    chk(p2_oe_n, 8'h0f);
    rfw(rmi_pkg::PORT2_ADDR, 8'h5a, 1'b0);
    rfr(rmi_pkg::PORT2_ADDR, q);
    chk(p2_out, 8'h5a);
    chk(q, 8'h50);
    rfr(rmi_pkg::P2_DIR_ADDR, q);
    chk(q, rmi_pkg::IDLE_READ);
    rfw(rmi_pkg::P01_CFG_ADDR, 8'h02, 1'b0);
    rfw(rmi_pkg::STACK_HI_ADDR, 8'h12, 1'b0);
    rfw(rmi_pkg::STACK_LO_ADDR, 8'h34, 1'b0);
    @(negedge mclk);
    chk({stack_external, stack_addr}, 17'h1_1234);
    stack_push = 1'b1;
    @(negedge mclk);
    stack_push = 1'b0;
    @(negedge mclk);
    chk(stack_addr, 16'h1233);
    rfw(rmi_pkg::P01_CFG_ADDR, 8'h06, 1'b0);
    @(negedge mclk);
    chk({stack_external, stack_addr}, 17'h0_0033);
    chk(p0_oe_n, 8'h00);
    rfw(rmi_pkg::IRQ_MASK_ADDR, 8'h3f, 1'b0);
    // bit 1 edge is hidden while data-space select is enabled
    p3_in = 4'h9;
    repeat (4) @(negedge mclk);
    chk(irq, 6'h01);
    rfr(rmi_pkg::IRQ_PEND_ADDR, q);
    chk(q, 8'h01);
    summarize();
  end
endmodule
